// >>> src/hpp_consts.svh
// timing and width constants for the host processor port
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH
`define HPP_ADDR_W 15
`define HPP_DATA_W 16
`define HPP_CLK_PERIOD_NS 40
// least gap after ack release, rounded up to whole clock cycles
`define HPP_GAP_NS 30
`define HPP_GAP_CYC ((`HPP_GAP_NS + `HPP_CLK_PERIOD_NS - 1) / `HPP_CLK_PERIOD_NS)
`define HPP_GAP_CNT_W 4
// cycles the device spends on an access before acknowledging
`define HPP_ACCESS_CYC 2
`define HPP_CNT_ZERO 4'h0
`define HPP_CNT_ONE 4'h1
`define HPP_MEM_DEPTH 32768
`define HPP_DIR_READ 1'b1
`define HPP_DIR_WRITE 1'b0
// select, strobe and direction at their released level
`define HPP_CTL_IDLE 3'h7
`endif

// >>> src/hpp_pkg.sv
// types shared by both ends of the host processor port
package hpp_pkg;
	typedef enum logic [1:0]
	{
		HPP_DEV_IDLE = 2'b00,
		HPP_DEV_WAIT = 2'b01,
		HPP_DEV_ACK = 2'b10
	} hpp_dev_state_e;
	typedef enum logic [2:0]
	{
		HPP_HOST_IDLE = 3'b000,
		HPP_HOST_SETUP = 3'b001,
		HPP_HOST_STROBE = 3'b010,
		HPP_HOST_RELEASE = 3'b011,
		HPP_HOST_GAP = 3'b100
	} hpp_host_state_e;
endpackage

// >>> src/hpp_if.sv
// interface joining processor and device ends of the port
`timescale 1ns/1ps
`include "hpp_consts.svh"
interface hpp_if;
	logic [`HPP_ADDR_W-1:0] host_address;
	logic port_select_n;
	logic data_strobe_n;
	logic read_write_dir;
	logic [`HPP_DATA_W-1:0] host_data_from_host;
	logic host_data_host_oe;
	logic [`HPP_DATA_W-1:0] host_data_from_dev;
	logic host_data_dev_oe;
	logic transfer_ack_n_out;
	logic transfer_ack_n_oe;
	modport host
	(
		output host_address, port_select_n, data_strobe_n, read_write_dir,
		output host_data_from_host, host_data_host_oe,
		input host_data_from_dev, host_data_dev_oe,
		input transfer_ack_n_out, transfer_ack_n_oe
	);
	modport dev
	(
		input host_address, port_select_n, data_strobe_n, read_write_dir,
		input host_data_from_host, host_data_host_oe,
		output host_data_from_dev, host_data_dev_oe,
		output transfer_ack_n_out, transfer_ack_n_oe
	);
endinterface

// >>> src/hpp_device.sv
// device end of the host processor port with its backing memory
// ==========================================================
`timescale 1ns/1ps
`include "hpp_consts.svh"
module hpp_device
	import hpp_pkg::*;
(
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// processor side
	hpp_if.dev bus,
	// status
	output logic o_busy
);
	// ==========================================================
	// input synchronisers
	// the processor handshake is asynchronous to i_ref_clk
	logic [2:0] ctl_meta_q;
	logic [2:0] ctl_sync_q;
	logic [`HPP_ADDR_W-1:0] addr_meta_q;
	logic [`HPP_ADDR_W-1:0] addr_sync_q;
	logic [`HPP_DATA_W-1:0] wdat_meta_q;
	logic [`HPP_DATA_W-1:0] wdat_sync_q;

	// control lines idle high, so reset loads the released level
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			ctl_meta_q <= `HPP_CTL_IDLE;
			ctl_sync_q <= `HPP_CTL_IDLE;
		end
		else if (i_clk_en)
		begin
			ctl_meta_q <= {bus.port_select_n, bus.data_strobe_n, bus.read_write_dir};
			ctl_sync_q <= ctl_meta_q;
		end
	end

	// address and data change with select, a cycle before strobe, so the handshake covers the word
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			addr_meta_q <= '0;
			addr_sync_q <= '0;
		end
		else if (i_clk_en)
		begin
			addr_meta_q <= bus.host_address;
			addr_sync_q <= addr_meta_q;
		end
	end

	// write data rides the same two-stage path as the address
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			wdat_meta_q <= '0;
			wdat_sync_q <= '0;
		end
		else if (i_clk_en)
		begin
			wdat_meta_q <= bus.host_data_from_host;
			wdat_sync_q <= wdat_meta_q;
		end
	end

	logic sel_n;
	logic stb_n;
	logic dir;
	logic access;
	assign sel_n = ctl_sync_q[2];
	assign stb_n = ctl_sync_q[1];
	assign dir = ctl_sync_q[0];
	assign access = !sel_n && !stb_n;

	// ==========================================================
	// memory behind the port
	logic [`HPP_DATA_W-1:0] mem [`HPP_MEM_DEPTH];
	logic [`HPP_DATA_W-1:0] rdat_q;

	// ==========================================================
	// access sequencer
	hpp_dev_state_e state_q;
	logic [`HPP_GAP_CNT_W-1:0] cnt_q;
	logic is_read_q;
	logic opening;
	logic wait_done;
	logic wr_fire;

	// wait counter expiry, shared by the sequencer, counter and memory
	function automatic logic count_last(input logic [`HPP_GAP_CNT_W-1:0] c);
		return c == `HPP_CNT_ONE;
	endfunction

	assign opening = (state_q == HPP_DEV_IDLE) && access;
	assign wait_done = (state_q == HPP_DEV_WAIT) && access && count_last(cnt_q);
	assign wr_fire = wait_done && !is_read_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			state_q <= HPP_DEV_IDLE;
		else if (i_clk_en)
		begin
			unique case (state_q)
				HPP_DEV_IDLE:
				begin
					if (access)
						state_q <= HPP_DEV_WAIT;
				end
				HPP_DEV_WAIT:
				begin
					// a host that drops strobe early aborts the access
					if (!access)
						state_q <= HPP_DEV_IDLE;
					else if (count_last(cnt_q))
						state_q <= HPP_DEV_ACK;
				end
				HPP_DEV_ACK:
				begin
					// hold ack until the host ends its cycle
					if (sel_n || stb_n)
						state_q <= HPP_DEV_IDLE;
				end
				default:
					state_q <= HPP_DEV_IDLE;
			endcase
		end
	end

	// wait counter: loaded as an access opens, runs down while it stays live
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			cnt_q <= `HPP_CNT_ZERO;
		else if (i_clk_en)
		begin
			if (opening)
				cnt_q <= `HPP_GAP_CNT_W'(`HPP_ACCESS_CYC);
			else if (state_q == HPP_DEV_WAIT && access && !count_last(cnt_q))
				cnt_q <= cnt_q - `HPP_CNT_ONE;
		end
	end

	// direction is fixed when the access opens and dropped when it closes
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			is_read_q <= 1'b0;
		else if (i_clk_en)
		begin
			if (opening)
				is_read_q <= (dir == `HPP_DIR_READ);
			else if (!access)
				is_read_q <= 1'b0;
		end
	end

	// a write lands only on the last wait cycle; reset aborts a pending one
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst_n && i_clk_en && wr_fire)
			mem[addr_sync_q] <= wdat_sync_q;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			rdat_q <= '0;
		else if (i_clk_en && state_q == HPP_DEV_WAIT && is_read_q)
			rdat_q <= mem[addr_sync_q];
	end

	// ==========================================================
	// pin drivers
	// data drive and ack drop on the same edge, so a host that waits for the
	// ack to clear can never drive into a read still on the bus
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			bus.host_data_dev_oe <= 1'b0;
		else if (i_clk_en)
			bus.host_data_dev_oe <= is_read_q && access && (state_q != HPP_DEV_IDLE);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			bus.transfer_ack_n_oe <= 1'b0;
		else if (i_clk_en)
			bus.transfer_ack_n_oe <= (state_q == HPP_DEV_ACK) && access;
	end

	assign bus.host_data_from_dev = rdat_q;
	assign bus.transfer_ack_n_out = 1'b0;
	assign o_busy = (state_q != HPP_DEV_IDLE);
endmodule

// >>> src/hpp_host.sv
// processor end of the host processor port
`timescale 1ns/1ps
`include "hpp_consts.svh"
module hpp_host
	import hpp_pkg::*;
(
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// user request
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [`HPP_ADDR_W-1:0] i_addr,
	input wire logic [`HPP_DATA_W-1:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic [`HPP_DATA_W-1:0] o_rdata,
	// device side
	hpp_if.host bus
);
	// ==========================================================
	// ack synchroniser; pulled-up line reads high when released
	logic ack_meta_q;
	logic ack_sync_q;
	logic ack_pin_n;
	assign ack_pin_n = bus.transfer_ack_n_oe ? bus.transfer_ack_n_out : 1'b1;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			ack_meta_q <= 1'b1;
			ack_sync_q <= 1'b1;
		end
		else if (i_clk_en)
		begin
			ack_meta_q <= ack_pin_n;
			ack_sync_q <= ack_meta_q;
		end
	end

	// ==========================================================
	// cycle sequencer
	hpp_host_state_e state_q;
	logic [`HPP_GAP_CNT_W-1:0] gap_q;
	logic [`HPP_ADDR_W-1:0] addr_q;
	logic [`HPP_DATA_W-1:0] wdat_q;
	logic write_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			state_q <= HPP_HOST_IDLE;
			gap_q <= `HPP_CNT_ZERO;
			addr_q <= '0;
			wdat_q <= '0;
			write_q <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= '0;
		end
		else if (i_clk_en)
		begin
			o_done <= 1'b0;
			unique case (state_q)
				HPP_HOST_IDLE:
				begin
					if (i_req)
					begin
						state_q <= HPP_HOST_SETUP;
						addr_q <= i_addr;
						wdat_q <= i_wdata;
						write_q <= i_write;
					end
				end
				HPP_HOST_SETUP:
					state_q <= HPP_HOST_STROBE;
				HPP_HOST_STROBE:
				begin
					if (!ack_sync_q)
					begin
						if (!write_q)
							o_rdata <= bus.host_data_from_dev;
						state_q <= HPP_HOST_RELEASE;
					end
				end
				HPP_HOST_RELEASE:
				begin
					if (ack_sync_q)
					begin
						state_q <= HPP_HOST_GAP;
						gap_q <= `HPP_GAP_CNT_W'(`HPP_GAP_CYC);
						o_done <= 1'b1;
					end
				end
				HPP_HOST_GAP:
				begin
					// spacing after ack release before the next select
					if (gap_q <= `HPP_CNT_ONE)
						state_q <= HPP_HOST_IDLE;
					else
						gap_q <= gap_q - `HPP_CNT_ONE;
				end
				default:
					state_q <= HPP_HOST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// pin drivers
	logic in_cycle;
	assign in_cycle = (state_q == HPP_HOST_SETUP) || (state_q == HPP_HOST_STROBE);
	assign bus.host_address = addr_q;
	assign bus.port_select_n = !in_cycle;
	assign bus.data_strobe_n = !(state_q == HPP_HOST_STROBE);
	assign bus.read_write_dir = write_q ? `HPP_DIR_WRITE : `HPP_DIR_READ;
	assign bus.host_data_from_host = wdat_q;
	assign bus.host_data_host_oe = in_cycle && write_q;
	assign o_ready = (state_q == HPP_HOST_IDLE);
endmodule

// >>> bench/hpp_port_props.sv
// assertion checker for the host processor port wires
`timescale 1ns/1ps
`include "hpp_consts.svh"
module hpp_port_props
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// port wires
	input wire logic [`HPP_ADDR_W-1:0] host_address,
	input wire logic port_select_n,
	input wire logic data_strobe_n,
	input wire logic read_write_dir,
	input wire logic [`HPP_DATA_W-1:0] host_data_from_host,
	input wire logic host_data_host_oe,
	input wire logic host_data_dev_oe,
	input wire logic transfer_ack_n_out,
	input wire logic transfer_ack_n_oe
);
	// ==========================================================
	// handshake properties
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_open;
		!port_select_n && !data_strobe_n;
	endsequence
	sequence s_closed;
		port_select_n && data_strobe_n;
	endsequence
	chk_ack_latency: assert property ($fell(data_strobe_n) ##0 s_open |-> ##[2:10] transfer_ack_n_oe)
		else $error("ack late");
	chk_ack_in_access: assert property ($rose(transfer_ack_n_oe) |-> s_open)
		else $error("ack outside access");
	chk_ack_low: assert property (transfer_ack_n_oe |-> !transfer_ack_n_out)
		else $error("ack not low");
	chk_read_drive: assert property ($rose(host_data_dev_oe) |-> s_open ##0 read_write_dir)
		else $error("device drives outside read");
	chk_no_contention: assert property (!(host_data_dev_oe && host_data_host_oe))
		else $error("both drive data");
	chk_write_dir: assert property (host_data_host_oe |-> !read_write_dir)
		else $error("host drives on read");
	chk_gap_hold: assert property ($fell(transfer_ack_n_oe) |=> s_closed)
		else $error("gap too short");
	chk_bus_stable: assert property (s_open ##1 s_open |-> $stable(host_address)
		&& ($stable(host_data_from_host) || !host_data_host_oe))
		else $error("bus moved in access");
	chk_reset_clear: assert property (disable iff (1'b0) !i_rst_n |=> !host_data_dev_oe
		&& !transfer_ack_n_oe && port_select_n)
		else $error("reset left port active");
	chk_drive_read: assert property (host_data_dev_oe |-> read_write_dir)
		else $error("device drives during write");
	chk_drive_ends: assert property ($fell(transfer_ack_n_oe) |-> !host_data_dev_oe)
		else $error("data drive outlives ack");
endmodule

// >>> bench/tb_host_processor_port.sv
// self-checking bench joining both ends of the host processor port
`timescale 1ns/1ps
`include "hpp_consts.svh"
module tb_host_processor_port;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_clk_en = 1'b1;
	logic i_req = 1'b0;
	logic i_write = 1'b0;
	logic [14:0] i_addr = 15'h0000;
	logic [15:0] i_wdata = 16'h0000;
	logic o_ready;
	logic o_done;
	logic o_busy;
	logic [15:0] o_rdata;
	logic [15:0] mem_model [int];
	logic [14:0] a_q [$];
	int bad_count = 0;
	int n_checks = 0;
	always #20 i_ref_clk = ~i_ref_clk;
	hpp_if bus_if ();
	hpp_host hpp_host_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
		.i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
		.o_done(o_done), .o_rdata(o_rdata), .bus(bus_if));
	hpp_device hpp_device_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
		.bus(bus_if), .o_busy(o_busy));
	hpp_port_props hpp_port_props_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.host_address(bus_if.host_address), .port_select_n(bus_if.port_select_n),
		.data_strobe_n(bus_if.data_strobe_n), .read_write_dir(bus_if.read_write_dir),
		.host_data_from_host(bus_if.host_data_from_host),
		.host_data_host_oe(bus_if.host_data_host_oe), .host_data_dev_oe(bus_if.host_data_dev_oe),
		.transfer_ack_n_out(bus_if.transfer_ack_n_out),
		.transfer_ack_n_oe(bus_if.transfer_ack_n_oe));
	// ==========================================================
	// shared tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic access(input logic wr, input logic [14:0] a, input logic [15:0] d);
		int n;
		logic r;
		@(posedge i_ref_clk);
		i_req <= 1'b1;
		i_write <= wr;
		i_addr <= a;
		i_wdata <= d;
		n = 0;
		do
		begin
			@(negedge i_ref_clk);
			r = o_ready;
			@(posedge i_ref_clk);
			n++;
		end
		while (r !== 1'b1 && n < 20);
		i_req <= 1'b0;
		n = 0;
		do
		begin
			@(negedge i_ref_clk);
			n++;
		end
		while (o_done !== 1'b1 && n < 60);
		check("done", {15'h0000, o_done}, 16'h0001);
		if (wr)
			mem_model[a] = d;
		else
			check("rdata", o_rdata, mem_model[a]);
		@(negedge i_ref_clk);
		check("done pulse", {15'h0000, o_done}, 16'h0000);
	endtask
	task automatic idle_check();
		check("rdata", o_rdata, 16'h0000);
		check("busy", {15'h0000, o_busy}, 16'h0000);
		check("ready", {15'h0000, o_ready}, 16'h0001);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial
	begin
		void'($urandom(32'hE410));
		repeat (10) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(negedge i_ref_clk);
		idle_check();
		$display("test reset done");
		for (int i = 0; i < `HPP_ADDR_W; i++) access(1'b1, 15'(1 << i), 16'(1 << i));
		access(1'b1, 15'h7FFF, 16'h8000);
		for (int i = 0; i < `HPP_ADDR_W; i++) access(1'b0, 15'(1 << i), 16'h0000);
		access(1'b0, 15'h7FFF, 16'h0000);
		$display("test bit order done");
		for (int i = 0; i < 16; i++)
		begin
			a_q.push_back(15'($urandom));
			access(1'b1, a_q[i], 16'($urandom));
		end
		foreach (a_q[i]) access(1'b0, a_q[i], 16'h0000);
		$display("test random done");
		// reset lands in mid-access; memory itself is not cleared
		@(posedge i_ref_clk);
		i_req <= 1'b1;
		i_write <= 1'b1;
		i_addr <= 15'h7FFE;
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		i_req <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(negedge i_ref_clk);
		idle_check();
		access(1'b0, 15'h7FFF, 16'h0000);
		$display("test mid reset done");
		// freeze both ends in mid-access; the read must resume intact
		fork
			access(1'b0, 15'h7FFF, 16'h0000);
			begin
				repeat (6) @(posedge i_ref_clk);
				i_clk_en <= 1'b0;
				repeat (2) @(posedge i_ref_clk);
				@(negedge i_ref_clk);
				check("busy frozen", {15'h0000, o_busy}, 16'h0001);
				@(posedge i_ref_clk);
				i_clk_en <= 1'b1;
			end
		join
		$display("test clock enable done");
		final_report();
	end
	initial
	begin
		repeat (5000) @(posedge i_ref_clk);
		bad_count++;
		final_report();
	end
endmodule
